/* File: caes_map.svh */
// Purpose: Register offsets, field positions and reset values for event select
// Assumes: APB word-aligned registers
// Notes: Included by the event select top
`ifndef CAES_MAP_SVH
`define CAES_MAP_SVH

`define CAES_OFF_CTRL     12'h000
`define CAES_OFF_COUNT    12'h004
`define CAES_OFF_STATUS   12'h008
`define CAES_CTRL_CODE_LO 0
`define CAES_CTRL_MASK_LO 8
`define CAES_CTRL_EN_BIT  16
`define CAES_CTRL_CLR_BIT 17
`define CAES_CTRL_RST     32'h0000_0000
`define CAES_EV_WBQ_CLASS  8'h28
`define CAES_EV_WBQ_REASON 8'h29
`define CAES_EV_FILT_EVICT 8'h3d
`define CAES_EV_SNP_SENT   8'h51
`define CAES_EV_SNP_RESP   8'h5c

`endif

/* File: caes_pkg.sv */
// Purpose: Types shared by the event select modules
// Assumes: Nothing
// Notes: Sub-event vectors are one bit per unit-mask position
package caes_pkg;

	typedef logic [7:0] caes_code_t;
	typedef logic [7:0] caes_umask_t;

	// Which event source the selected code maps to
	typedef enum logic [2:0] {
		CAES_SRC_NONE,
		CAES_SRC_WBQ_CLASS,
		CAES_SRC_WBQ_REASON,
		CAES_SRC_FILT_EVICT,
		CAES_SRC_SNP_SENT,
		CAES_SRC_SNP_RESP
	} caes_src_t;

	// Snoop-sent hit: one snoop with its origin and kind
	typedef struct packed {
		logic valid;
		logic remote;
		logic directed;
	} caes_snoop_t;

endpackage

/* File: caes_qual_if.sv */
// Purpose: Carries selection and qualified hit count between modules
// Assumes: Single clock domain
// Notes: Selector drives code and mask, qualifier returns increment
`timescale 1ns/10ps
`default_nettype none
interface caes_qual_if;
	import caes_pkg::*;
	caes_code_t  code;
	caes_umask_t umask;
	logic [3:0]  incr;
	modport sel (output code, output umask, input incr);
	modport qual (input code, input umask, output incr);
endinterface
`default_nettype wire

/* File: caes_qualify.sv */
// Purpose: Qualifies incoming event hits by event code and unit mask
// Assumes: Hit vectors are one cycle pulses from the agent pipelines
// Notes: Registered increment; one cycle of latency
`timescale 1ns/10ps
`default_nettype none
module caes_qualify
	import caes_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Selection and result
	caes_qual_if.qual        qif,
	// Event sources
	input  wire logic [7:0]  wbq_class_hit,
	input  wire logic [7:0]  wbq_reason_hit,
	input  wire logic [2:0]  filter_evict_hit,
	input  wire caes_snoop_t snoop_sent,
	input  wire logic [7:0]  snoop_response_event_hit
);
	`include "caes_map.svh"

	typedef struct packed {
		logic [3:0] incr;
	} caes_qst_t;

	caes_qst_t st_q, st_d;

	// Count of set bits in a masked hit vector
	function automatic logic [3:0] pop8(input logic [7:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, v[i]};
		end
		return n;
	endfunction

	// Select source and count matching sub-events
	always_comb begin
		logic [7:0] snp;
		snp = 8'h00;
		st_d = st_q;
		// Snoop sent hit expanded to mask positions
		snp[0] = snoop_sent.valid;
		snp[2] = snoop_sent.valid & ~snoop_sent.remote;
		snp[3] = snoop_sent.valid & snoop_sent.remote;
		snp[4] = snoop_sent.valid & ~snoop_sent.remote & ~snoop_sent.directed;
		snp[5] = snoop_sent.valid & snoop_sent.remote & ~snoop_sent.directed;
		snp[6] = snoop_sent.valid & ~snoop_sent.remote & snoop_sent.directed;
		snp[7] = snoop_sent.valid & snoop_sent.remote & snoop_sent.directed;
		case (qif.code)
			`CAES_EV_WBQ_CLASS: begin
				st_d.incr = pop8(wbq_class_hit & qif.umask);
			end
			`CAES_EV_WBQ_REASON: begin
				st_d.incr = pop8(wbq_reason_hit & qif.umask);
			end
			`CAES_EV_FILT_EVICT: begin
				st_d.incr = pop8({5'h00, filter_evict_hit} & qif.umask);
			end
			`CAES_EV_SNP_SENT: begin
				st_d.incr = pop8(snp & qif.umask);
			end
			`CAES_EV_SNP_RESP: begin
				st_d.incr = pop8(snoop_response_event_hit & qif.umask);
			end
			default: begin
				st_d.incr = 4'h0;
			end
		endcase
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign qif.incr = st_q.incr;
endmodule
`default_nettype wire

/* File: caes_event_select.sv */
// Purpose: Event selection, qualification and counting for a caching agent
// Assumes: APB slave, 20 MHz pclk, hit inputs synchronous pulses
// Notes: Control holds code, mask, enable, clear; count register is read/write
// Function
// - Code 28h counts writeback-queue retries by class
// - Code 29h counts writeback-queue retries by reason
// - Code 3dh counts filter evictions by state
// - Code 51h mask bit0 counts all snoops
// - Mask bits 4,5 count local/remote broadcasts
// - Mask bits 6,7 count local/remote directed snoops
// - Code 5ch counts each snoop response
// - Mask bits 2,3 count forwarding responses
// - Mask bits 4,5 count writeback responses
// - Mask bit 6 counts conflict responses
// - Mask bit 7 counts plain forward responses
`timescale 1ns/10ps
`default_nettype none
module caes_event_select
	import caes_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Writeback queue retries
	input  wire logic [7:0]  wbq_retry_by_class,
	input  wire logic [7:0]  wbq_retry_by_reason,
	// Snoop filter evictions: bit0 M, bit1 E, bit2 S
	input  wire logic [2:0]  filter_eviction_event,
	// Snoop sent pulse and qualifiers
	input  wire logic        snoop_sent_valid,
	input  wire logic        snoop_sent_remote,
	input  wire logic        snoop_sent_directed,
	// Snoop responses, one bit per response kind
	input  wire logic [7:0]  snoop_response_event,
	// Counter status
	output logic      [31:0] event_count
);
	`include "caes_map.svh"

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] count;
		logic        ovf;
		logic [31:0] rdata;
		logic        err;
	} caes_st_t;

	caes_st_t st_q, st_d;
	caes_qual_if qif();
	caes_snoop_t snoop_in;

	// Access phase strobe, used by the write and error paths
	function automatic logic apb_access(input logic s, input logic e);
		return s & e;
	endfunction

	// Map a code to its source kind, for status readback
	function automatic caes_src_t code_src(input logic [7:0] c);
		caes_src_t k;
		k = CAES_SRC_NONE;
		if (c == `CAES_EV_WBQ_CLASS) begin
			k = CAES_SRC_WBQ_CLASS;
		end else if (c == `CAES_EV_WBQ_REASON) begin
			k = CAES_SRC_WBQ_REASON;
		end else if (c == `CAES_EV_FILT_EVICT) begin
			k = CAES_SRC_FILT_EVICT;
		end else if (c == `CAES_EV_SNP_SENT) begin
			k = CAES_SRC_SNP_SENT;
		end else if (c == `CAES_EV_SNP_RESP) begin
			k = CAES_SRC_SNP_RESP;
		end
		return k;
	endfunction

	// Programmed selection towards the qualifier
	assign qif.code  = st_q.ctrl[`CAES_CTRL_CODE_LO +: 8];
	assign qif.umask = st_q.ctrl[`CAES_CTRL_MASK_LO +: 8];
	assign snoop_in  = '{valid: snoop_sent_valid, remote: snoop_sent_remote,
		directed: snoop_sent_directed};

	caes_qualify u_qual (
		.pclk             (pclk),
		.presetn          (presetn),
		.qif              (qif),
		.wbq_class_hit    (wbq_retry_by_class),
		.wbq_reason_hit   (wbq_retry_by_reason),
		.filter_evict_hit (filter_eviction_event),
		.snoop_sent       (snoop_in),
		.snoop_response_event_hit   (snoop_response_event)
	);

	// Register file, counter and bus answer
	always_comb begin
		logic        acc;
		logic        en;
		logic [32:0] sum;
		acc = apb_access(psel, penable);
		en  = st_q.ctrl[`CAES_CTRL_EN_BIT];
		sum = {1'b0, st_q.count} + {29'h0, qif.incr};
		st_d = st_q;
		st_d.err = 1'b0;
		// Error stands through the whole access phase
		if (acc) begin
			st_d.err = st_q.err;
		end
		st_d.ctrl[`CAES_CTRL_CLR_BIT] = 1'b0;
		// Counter advances by every qualified sub-event while enabled, except in a clear cycle or a cycle that writes the count register
		if (st_q.ctrl[`CAES_CTRL_CLR_BIT]) begin
			st_d.count = 32'h0;
			st_d.ovf   = en & sum[32]; // Overflow in the clearing cycle still sets
		end else if (en) begin
			st_d.count = sum[31:0];
			st_d.ovf   = st_q.ovf | sum[32];
		end
		// Decode of the setup phase
		if (psel && !penable) begin
			if (paddr == `CAES_OFF_CTRL) begin
				st_d.rdata = st_q.ctrl;
			end else if (paddr == `CAES_OFF_COUNT) begin
				st_d.rdata = st_q.count;
			end else if (paddr == `CAES_OFF_STATUS) begin
				st_d.rdata = {28'h0, st_q.ovf, code_src(qif.code)};
			end else begin
				st_d.rdata = 32'h0;
			end
		end
		if (acc && pwrite) begin
			if (paddr == `CAES_OFF_CTRL) begin
				st_d.ctrl = {14'h0, pwdata[17:0]};
			end else if (paddr == `CAES_OFF_COUNT) begin
				st_d.count = pwdata;
			end else if (paddr != `CAES_OFF_STATUS) begin
				st_d.err = 1'b1;
			end
		end
		if (psel && !penable && paddr != `CAES_OFF_CTRL && paddr != `CAES_OFF_COUNT
			&& paddr != `CAES_OFF_STATUS) begin
			st_d.err = 1'b1;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= '{ctrl: `CAES_CTRL_RST, count: 32'h0, ovf: 1'b0,
				rdata: 32'h0, err: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs: zero wait state slave
	assign pready      = 1'b1;
	assign prdata      = st_q.rdata;
	assign pslverr     = st_q.err & psel & penable;
	assign event_count = st_q.count;
endmodule
`default_nettype wire

/* File: caes_monitor.sv */
// Purpose: Port-level checks for event select
// Assumes: Aligned APB addresses
// Notes: Keeps a shadow of the control word
`timescale 1ns/10ps
`default_nettype none
module caes_monitor (
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Hits and count
	input wire logic [7:0]  wbq_retry_by_class,
	input wire logic [7:0]  wbq_retry_by_reason,
	input wire logic [2:0]  filter_eviction_event,
	input wire logic        snoop_sent_valid,
	input wire logic [7:0]  snoop_response_event,
	input wire logic [31:0] event_count
);
	logic        acc;
	logic        wr;
	logic        hit;
	logic [17:0] ctl_q;
	// Access phase, write, any hit
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign hit = |{wbq_retry_by_class, wbq_retry_by_reason, filter_eviction_event,
		snoop_sent_valid, snoop_response_event};
	// Shadow control word
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctl_q <= 18'h0;
		else if (wr && paddr == 12'h000)
			ctl_q <= pwdata[17:0];
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	AST_READY: assert property (pready) else $error("not ready");
	AST_ERR_MAP: assert property (acc && !(paddr inside {12'h000, 12'h004, 12'h008}) |-> pslverr)
		else $error("no error");
	AST_ERR_OK: assert property (acc && (paddr inside {12'h000, 12'h004, 12'h008}) |-> !pslverr)
		else $error("bad error");
	AST_RST: assert property ($rose(presetn) |-> event_count == 0 && prdata == 0)
		else $error("reset value");
	AST_QUIET: assert property ((!wr && !hit)[*3] |=> $stable(event_count))
		else $error("count moved");
	AST_BOUND: assert property (!wr[*2] |=> event_count - $past(event_count) <= 32'd8)
		else $error("step too big");
	AST_DIS: assert property ((!ctl_q[16] && !wr)[*3] |=> $stable(event_count))
		else $error("counts when off");
	AST_CODE: assert property ((!(ctl_q[7:0] inside {8'h28, 8'h29, 8'h3d, 8'h51, 8'h5c})
		&& !wr)[*3] |=> $stable(event_count)) else $error("bad code counts");
	AST_MASK: assert property ((ctl_q[15:8] == 8'h00 && !wr)[*3] |=> $stable(event_count))
		else $error("empty mask counts");
	// Main scenarios
	cover property (acc && pslverr);
	cover property (!wr ##1 $changed(event_count));
	cover property (ctl_q[16] && ctl_q[7:0] == 8'h51 && snoop_sent_valid);
endmodule
bind caes_event_select caes_monitor u_mon (.*);
`default_nettype wire

/* File: caes_src_model.sv */
// Purpose: Hit source model of the agent pipelines
// Assumes: One occurrence per set bit
// Notes: Silent unless enabled
`timescale 1ns/10ps
`default_nettype none
module caes_src_model (
	// Clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        on,
	// Packed hit vectors
	output logic      [29:0] hits
);
	int seed = 79893;
	// Sparse random hits while enabled
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hits <= 30'h0;
		else
			hits <= on ? 30'($random(seed) & $random(seed)) : 30'h0;
	end
endmodule
`default_nettype wire

/* File: tb_cache_agent_event_select.sv */
// Purpose: Self-checking bench for event select
// Assumes: APB slave answers via pready
// Notes: Expected counts built from observed hits
`timescale 1ns/10ps
`default_nettype none
`define CHK(x, y) begin comparisons++; if ((x) !== (y)) begin error_cnt++; \
	$display("unexpected at %0t: got %h want %h", $time, x, y); end end
module tb_cache_agent_event_select;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, on = 0, pready;
	logic        pslverr, er;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd, wv, cnt, exp_cnt;
	logic [29:0] hits;
	logic [17:0] ctl;
	logic [7:0]  codes [6] = '{8'h28, 8'h29, 8'h3d, 8'h51, 8'h5c, 8'h00};
	int          seed = 79893, error_cnt = 0, comparisons = 0;
	caes_event_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .wbq_retry_by_class(hits[29:22]), .wbq_retry_by_reason(hits[21:14]),
		.filter_eviction_event(hits[13:11]), .snoop_sent_valid(hits[10]),
		.snoop_sent_remote(hits[9]), .snoop_sent_directed(hits[8]),
		.snoop_response_event(hits[7:0]), .event_count(cnt));
	caes_src_model src (.pclk(pclk), .presetn(presetn), .on(on), .hits(hits));
	// Sub-events of one cycle for a code
	function automatic logic [7:0] subev(logic [7:0] c, logic [29:0] h);
		logic v, r, d;
		v = h[10];
		r = h[9];
		d = h[8];
		case (c)
			8'h28: return h[29:22];
			8'h29: return h[21:14];
			8'h3d: return {5'h0, h[13:11]};
			8'h51: return {v & r & d, v & !r & d, v & r & !d, v & !r & !d, v & r, v & !r, 1'b0, v};
			8'h5c: return h[7:0];
			default: return 8'h0;
		endcase
	endfunction
	// Expected count from sampled hits
	always @(posedge pclk)
		if (ctl[16] && |hits)
			exp_cnt <= exp_cnt + 32'($countones(subev(ctl[7:0], hits) & ctl[15:8]));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic summarize();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial forever #25 pclk = ~pclk;
	// Watchdog
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values, unmapped read and write
		for (int k = 0; k < 16; k += 4) begin
			apb(1'b0, 12'(k), 32'h0);
			`CHK(rd, 32'h0)
			`CHK(er, k == 12)
		end
		apb(1'b1, 12'hffc, 32'h1);
		`CHK(er, 1'b1)
		for (int i = 0; i < 6; i++)
			for (int j = 0; j < 10; j++) begin
				ctl = {1'b1, (j != 9) | 1'($random(seed)),
					j < 8 ? 8'h01 << j : j == 8 ? 8'hff : 8'($random(seed)), codes[i]};
				wv = $random(seed);
				apb(1'b1, 12'h004, wv);
				apb(1'b0, 12'h004, 32'h0);
				`CHK(rd, wv)
				apb(1'b1, 12'h000, {14'h0, ctl});
				exp_cnt = 32'h0;
				apb(1'b1, 12'h008, 32'hffff_ffff);
				apb(1'b0, 12'h008, 32'h0);
				`CHK(rd[3:0], {1'b0, i < 5 ? 3'(i + 1) : 3'h0})
				on <= 1'b1;
				repeat (20) @(posedge pclk);
				on <= 1'b0;
				repeat (6) @(posedge pclk);
				apb(1'b0, 12'h004, 32'h0);
				`CHK(rd, exp_cnt)
				`CHK(cnt, exp_cnt)
			end
		summarize();
	end
endmodule
`default_nettype wire
